// >>> aos_pkg.sv
// Shared constants for the accumulator and operand substitution executor.
// Assumes one synchronous clock domain; opcode values are local encodings.
package aos_pkg;

   // Instruction word layout
   localparam int          OP_MSB       = 15;
   localparam int          OP_LSB       = 8;
   localparam int          TWO_WORD_BIT = 15;

   // Opcodes executed or steered by this block
   localparam logic [7:0]  OP_FLOAT_TO_FIXED  = 8'h10;
   localparam logic [7:0]  OP_ONES_COMPLEMENT = 8'h11;
   localparam logic [7:0]  OP_TWOS_COMPLEMENT = 8'h12;
   localparam logic [7:0]  OP_BYTE_INCREMENT  = 8'h13;
   localparam logic [7:0]  OP_BYTE_DECREMENT  = 8'h14;
   localparam logic [7:0]  OP_DATA_WORD_EXEC  = 8'h20;
   localparam logic [7:0]  OP_FLAG_WORD_EXEC  = 8'h21;
   localparam logic [7:0]  OP_FORMAL_EXEC     = 8'h22;
   localparam logic [7:0]  OP_INDIRECT_FORMAL = 8'h23;
   localparam logic [7:0]  OP_SYSTEM_DATA     = 8'h24;
   localparam logic [7:0]  OP_OPEN_DATA_BLOCK = 8'h30;
   localparam logic [7:0]  OP_CALL_PROGRAM    = 8'h31;
   localparam logic [7:0]  OP_CALL_ORG        = 8'h32;
   localparam logic [7:0]  OP_CALL_FUNCTION   = 8'h33;
   localparam logic [7:0]  OP_CALL_SEQUENCE   = 8'h34;

   // Parameter memory spaces
   localparam logic [1:0]  SPACE_DATA_WORD   = 2'h0;
   localparam logic [1:0]  SPACE_FLAG_WORD   = 2'h1;
   localparam logic [1:0]  SPACE_FORMAL      = 2'h2;
   localparam logic [1:0]  SPACE_SYSTEM_DATA = 2'h3;

   // Free system data window
   localparam logic [7:0]  SYSTEM_DATA_FIRST = 8'h3c;
   localparam logic [7:0]  SYSTEM_DATA_LAST  = 8'h3f;

   // Float layout: exponent 31..24, signed mantissa 23..0
   localparam int          MANT_MSB      = 23;
   localparam int          EXP_LSB       = 24;
   localparam logic signed [8:0] MANT_FRAC_BITS = 9'sd23;
   localparam logic [5:0]  SHIFT_CAP     = 6'h3f;

   // Reset values
   localparam logic [31:0] ACC_RESET   = 32'h0000_0000;
   localparam logic [15:0] WORD_RESET  = 16'h0000;

   // Sequencer states, Gray-coded in listed order
   typedef enum logic [2:0] {
      S_IDLE         = 3'b000,
      S_FETCH_PARAM  = 3'b001,
      S_FETCH_CODE   = 3'b011,
      S_FETCH_SECOND = 3'b010,
      S_RUN          = 3'b110,
      S_CONVERT      = 3'b111
   } aos_state_t;

endpackage

// >>> aos_float_to_fixed.sv
// Float to 32-bit fixed point converter with registered result.
// Assumes a one-cycle start pulse; result is valid with done one cycle later.
module aos_float_to_fixed
(
   // Clock and reset
   input  wire logic        i_clock,
   input  wire logic        i_srst,
   // Request
   input  wire logic        i_start,
   input  wire logic [31:0] i_value,
   // Result
   output logic             o_done,
   output logic [31:0]      o_result
);

   logic signed [63:0] mant_ext;
   logic signed [8:0]  exp_ext;
   logic signed [8:0]  shift_diff;
   logic signed [8:0]  shift_neg;
   logic [5:0]         shift_amt;
   logic signed [63:0] shifted;
   logic               remainder;
   logic [31:0]        result_d;
   logic [31:0]        result_q;
   logic               done_q;

   always_comb
   begin
      mant_ext   = {{40{i_value[aos_pkg::MANT_MSB]}}, i_value[aos_pkg::MANT_MSB:0]};
      exp_ext    = {i_value[31], i_value[31:aos_pkg::EXP_LSB]};
      shift_diff = 9'(exp_ext - aos_pkg::MANT_FRAC_BITS);
      shift_neg  = 9'(-shift_diff);
      remainder  = 1'b0;
      if (shift_diff >= 0)
      begin
         shift_amt = (shift_diff > $signed({3'h0, aos_pkg::SHIFT_CAP})) ?
                     aos_pkg::SHIFT_CAP : shift_diff[5:0];
         shifted   = mant_ext <<< shift_amt;
      end
      else
      begin
         shift_amt = (shift_neg > $signed({3'h0, aos_pkg::SHIFT_CAP})) ?
                     aos_pkg::SHIFT_CAP : shift_neg[5:0];
         shifted   = mant_ext >>> shift_amt;
         remainder = |(mant_ext & ((64'h1 << shift_amt) - 64'h1));
      end
      result_d = shifted[31:0];
      // Cut fraction floors; open interval (-1,0) gives zero
      if ((result_d == 32'hffff_ffff) && remainder)  // RL1
      begin
         result_d = 32'h0000_0000;
      end
   end

   always_ff @(posedge i_clock)
   begin
      if (i_srst)
      begin
         result_q <= aos_pkg::ACC_RESET;
         done_q   <= 1'b0;
      end
      else
      begin
         result_q <= i_start ? result_d : result_q;
         done_q   <= i_start;
      end
   end

   assign o_done   = done_q;
   assign o_result = result_q;

endmodule // aos_float_to_fixed

// >>> aos_executor.sv
// Accumulator arithmetic and operand substitution executor.
// Assumes the parameter memory and the instruction source share I_CLOCK.
//
// Overview of operation
// RL1 - Float conversion floors, zero inside minus one
// RL2 - One's complement inverts accumulator low word
// RL3 - Two's complement negates accumulator low word
// RL4 - Byte decrement subtracts operand from low byte
// RL5 - Byte increment adds operand to low byte
// RL6 - Byte arithmetic wraps, no carry upward
// RL7 - Byte arithmetic runs unconditionally
// RL8 - Data word prefix substitutes next operand
// RL9 - Flag word prefix substitutes next operand
// RL10 - Formal prefix: block parameters, block ops only
// RL11 - Indirect formal number comes from accumulator
// RL12 - System data code, second word follows
// RL13 - Fetched code decoded as ordinary instruction
// RL14 - Program combines prefixes only with permitted ops
// RL15 - Substitution replaces value, keeps operand type
// RL16 - Prefix directly followed by its target
// RL17 - Program writes parameter word before prefix
// RL18 - Byte arithmetic keeps upper accumulator bits
// RL19 - Illegal combinations undefined; formal prefix misuse and system data outside the window raise O_SUBST_REJECT
module aos_executor
(
   // Clock and reset
   input  wire logic        I_CLOCK,
   input  wire logic        I_SRST,
   // Instruction stream
   input  wire logic        I_INSTR_VALID,
   input  wire logic [15:0] I_INSTR_WORD,
   input  wire logic [15:0] I_INSTR_EXT,
   output logic             O_INSTR_READY,
   // Accumulator load from other execution units
   input  wire logic        I_ACC_LOAD_VALID,
   input  wire logic [31:0] I_ACC_LOAD_DATA,
   output logic [31:0]      O_ACCUMULATOR,
   // Parameter memory read port
   output logic             O_MEM_REQ,
   output logic [1:0]       O_MEM_SPACE,
   output logic [7:0]       O_MEM_ADDR,
   input  wire logic        I_MEM_ACK,
   input  wire logic [15:0] I_MEM_DATA,
   input  wire logic        I_MEM_BLOCK_TYPE,
   // Dispatched instruction
   output logic             O_EXEC_VALID,
   output logic [15:0]      O_EXEC_WORD,
   output logic [15:0]      O_EXEC_OPERAND,
   output logic             O_EXEC_SUBST,
   output logic             O_SUBST_REJECT
);

   aos_pkg::aos_state_t state_q, state_d;
   logic [31:0] acc_q, acc_d;
   logic        subst_valid_q, subst_valid_d;
   logic        subst_formal_q, subst_formal_d;
   logic [15:0] subst_val_q, subst_val_d;
   logic [15:0] code_q, code_d;
   logic [15:0] ext_q, ext_d;
   logic        mem_req_q, mem_req_d;
   logic [1:0]  space_q, space_d;
   logic [7:0]  addr_q, addr_d;
   logic        exec_valid_q, exec_valid_d;
   logic [15:0] exec_word_q, exec_word_d;
   logic [15:0] exec_operand_q, exec_operand_d;
   logic        exec_subst_q, exec_subst_d;
   logic        reject_q, reject_d;
   logic [15:0] cur_word;
   logic [15:0] cur_ext;
   logic        cur_go;
   logic [7:0]  op;
   logic [7:0]  arg;
   logic        is_block_op;
   logic        use_sub;
   logic [7:0]  amount;
   logic        conv_start;
   logic        conv_done;
   logic [31:0] conv_result;

   aos_float_to_fixed u_convert
   (
      .i_clock  (I_CLOCK),
      .i_srst   (I_SRST),
      .i_start  (conv_start),
      .i_value  (acc_q),
      .o_done   (conv_done),
      .o_result (conv_result)
   );

   always_comb
   begin
      // Fetched code runs through the same decode as the stream
      cur_word = (state_q == aos_pkg::S_RUN) ? code_q : I_INSTR_WORD;  // RL13
      cur_ext  = (state_q == aos_pkg::S_RUN) ? ext_q : I_INSTR_EXT;
      cur_go   = (state_q == aos_pkg::S_RUN) ||
                 ((state_q == aos_pkg::S_IDLE) && I_INSTR_VALID);
      op  = cur_word[aos_pkg::OP_MSB:aos_pkg::OP_LSB];
      arg = cur_word[7:0];
      is_block_op = (op == aos_pkg::OP_OPEN_DATA_BLOCK) || (op == aos_pkg::OP_CALL_PROGRAM) ||
                    (op == aos_pkg::OP_CALL_ORG) || (op == aos_pkg::OP_CALL_FUNCTION) ||
                    (op == aos_pkg::OP_CALL_SEQUENCE);
      // Formal substitution applies to block ops only
      use_sub = subst_valid_q && (!subst_formal_q || is_block_op);  // RL10
      amount  = use_sub ? subst_val_q[7:0] : arg;
   end

   always_comb
   begin
      state_d        = state_q;
      acc_d          = I_ACC_LOAD_VALID ? I_ACC_LOAD_DATA : acc_q;
      subst_valid_d  = subst_valid_q;
      subst_formal_d = subst_formal_q;
      subst_val_d    = subst_val_q;
      code_d         = code_q;
      ext_d          = ext_q;
      mem_req_d      = mem_req_q;
      space_d        = space_q;
      addr_d         = addr_q;
      exec_valid_d   = 1'b0;
      exec_word_d    = exec_word_q;
      exec_operand_d = exec_operand_q;
      exec_subst_d   = exec_subst_q;
      reject_d       = 1'b0;
      conv_start     = 1'b0;
      case (state_q)
         aos_pkg::S_IDLE,
         aos_pkg::S_RUN:
         begin
            if (cur_go)
            begin
               state_d = aos_pkg::S_IDLE;
               case (op)
                  aos_pkg::OP_DATA_WORD_EXEC,
                  aos_pkg::OP_FLAG_WORD_EXEC,
                  aos_pkg::OP_FORMAL_EXEC:
                  begin
                     // Parameter word read; target comes next
                     mem_req_d      = 1'b1;  // RL8 RL9
                     addr_d         = arg;
                     space_d        = (op == aos_pkg::OP_DATA_WORD_EXEC) ?
                                      aos_pkg::SPACE_DATA_WORD :
                                      (op == aos_pkg::OP_FLAG_WORD_EXEC) ?
                                      aos_pkg::SPACE_FLAG_WORD : aos_pkg::SPACE_FORMAL;
                     subst_formal_d = (op == aos_pkg::OP_FORMAL_EXEC);  // RL10
                     subst_valid_d  = 1'b0;
                     state_d        = aos_pkg::S_FETCH_PARAM;
                  end
                  aos_pkg::OP_INDIRECT_FORMAL:
                  begin
                     mem_req_d = 1'b1;
                     space_d   = aos_pkg::SPACE_FORMAL;
                     addr_d    = acc_q[7:0];  // RL11
                     ext_d     = aos_pkg::WORD_RESET;
                     state_d   = aos_pkg::S_FETCH_CODE;
                  end
                  aos_pkg::OP_SYSTEM_DATA:
                  begin
                     ext_d = aos_pkg::WORD_RESET;
                     if ((arg >= aos_pkg::SYSTEM_DATA_FIRST) && (arg <= aos_pkg::SYSTEM_DATA_LAST))
                     begin
                        mem_req_d = 1'b1;  // RL12
                        space_d   = aos_pkg::SPACE_SYSTEM_DATA;
                        addr_d    = arg;
                        state_d   = aos_pkg::S_FETCH_CODE;
                     end
                     else
                     begin
                        reject_d = 1'b1;
                     end
                  end
                  default:
                  begin
                     subst_valid_d = 1'b0;
                     // Legality of combinations is the program's duty
                     reject_d      = subst_valid_q && !use_sub;  // RL14 RL19
                     case (op)
                        aos_pkg::OP_FLOAT_TO_FIXED:
                        begin
                           conv_start = 1'b1;  // RL1
                           state_d    = aos_pkg::S_CONVERT;
                        end
                        aos_pkg::OP_ONES_COMPLEMENT:
                        begin
                           acc_d[15:0] = ~acc_q[15:0];  // RL2
                           acc_d[31:16] = acc_q[31:16];
                        end
                        aos_pkg::OP_TWOS_COMPLEMENT:
                        begin
                           acc_d[15:0] = 16'(16'h0000 - acc_q[15:0]);  // RL3
                           acc_d[31:16] = acc_q[31:16];
                        end
                        aos_pkg::OP_BYTE_INCREMENT,
                        aos_pkg::OP_BYTE_DECREMENT:
                        begin
                           // Regardless of condition codes, wraps in byte
                           acc_d[7:0] = (op == aos_pkg::OP_BYTE_INCREMENT) ?
                                        8'(acc_q[7:0] + amount) :
                                        8'(acc_q[7:0] - amount);  // RL4 RL5 RL6 RL7
                           acc_d[31:8] = acc_q[31:8];  // RL18
                        end
                        default:
                        begin
                           // Type stays encoded in the word, value replaced
                           exec_valid_d   = 1'b1;
                           exec_word_d    = cur_word;  // RL15
                           exec_operand_d = use_sub ? subst_val_q :
                                            (op[7] ? cur_ext : {8'h00, arg});
                           exec_subst_d   = use_sub;
                        end
                     endcase
                  end
               endcase
            end
         end
         aos_pkg::S_FETCH_PARAM:
         begin
            if (I_MEM_ACK)
            begin
               // Parameter held for the very next instruction
               mem_req_d     = 1'b0;
               subst_val_d   = I_MEM_DATA;
               subst_valid_d = !(subst_formal_q && !I_MEM_BLOCK_TYPE);  // RL16 RL10
               reject_d      = subst_formal_q && !I_MEM_BLOCK_TYPE;
               state_d       = aos_pkg::S_IDLE;
            end
         end
         aos_pkg::S_FETCH_CODE:
         begin
            if (I_MEM_ACK)
            begin
               code_d = I_MEM_DATA;
               if (I_MEM_DATA[aos_pkg::TWO_WORD_BIT] && (space_q == aos_pkg::SPACE_SYSTEM_DATA))
               begin
                  addr_d  = 8'(addr_q + 8'h01);  // RL12
                  state_d = aos_pkg::S_FETCH_SECOND;
               end
               else
               begin
                  mem_req_d = 1'b0;
                  state_d   = aos_pkg::S_RUN;
               end
            end
         end
         aos_pkg::S_FETCH_SECOND:
         begin
            if (I_MEM_ACK)
            begin
               ext_d     = I_MEM_DATA;
               mem_req_d = 1'b0;
               state_d   = aos_pkg::S_RUN;
            end
         end
         aos_pkg::S_CONVERT:
         begin
            if (conv_done)
            begin
               acc_d   = conv_result;  // RL1
               state_d = aos_pkg::S_IDLE;
            end
         end
         default:
         begin
            state_d   = aos_pkg::S_IDLE;
            mem_req_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge I_CLOCK)
   begin
      if (I_SRST)
      begin
         state_q        <= aos_pkg::S_IDLE;
         acc_q          <= aos_pkg::ACC_RESET;
         subst_valid_q  <= 1'b0;
         subst_formal_q <= 1'b0;
         subst_val_q    <= aos_pkg::WORD_RESET;
         code_q         <= aos_pkg::WORD_RESET;
         ext_q          <= aos_pkg::WORD_RESET;
         mem_req_q      <= 1'b0;
         space_q        <= aos_pkg::SPACE_DATA_WORD;
         addr_q         <= 8'h00;
         exec_valid_q   <= 1'b0;
         exec_word_q    <= aos_pkg::WORD_RESET;
         exec_operand_q <= aos_pkg::WORD_RESET;
         exec_subst_q   <= 1'b0;
         reject_q       <= 1'b0;
      end
      else
      begin
         state_q        <= state_d;
         acc_q          <= acc_d;
         subst_valid_q  <= subst_valid_d;
         subst_formal_q <= subst_formal_d;
         subst_val_q    <= subst_val_d;
         code_q         <= code_d;
         ext_q          <= ext_d;
         mem_req_q      <= mem_req_d;
         space_q        <= space_d;
         addr_q         <= addr_d;
         exec_valid_q   <= exec_valid_d;
         exec_word_q    <= exec_word_d;
         exec_operand_q <= exec_operand_d;
         exec_subst_q   <= exec_subst_d;
         reject_q       <= reject_d;
      end
   end

   assign O_INSTR_READY  = (state_q == aos_pkg::S_IDLE);
   assign O_ACCUMULATOR  = acc_q;
   assign O_MEM_REQ      = mem_req_q;
   assign O_MEM_SPACE    = space_q;
   assign O_MEM_ADDR     = addr_q;
   assign O_EXEC_VALID   = exec_valid_q;
   assign O_EXEC_WORD    = exec_word_q;
   assign O_EXEC_OPERAND = exec_operand_q;
   assign O_EXEC_SUBST   = exec_subst_q;
   assign O_SUBST_REJECT = reject_q;

   // Checks
   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (I_SRST);

   AST_CONVERT_LOAD: assert property (conv_done |=> acc_q == $past(conv_result))  // RL1
      else $error("Converted value not loaded");
   AST_ONES: assert property ((cur_go && op == aos_pkg::OP_ONES_COMPLEMENT) |=>  // RL2
      (acc_q[15:0] == ~$past(acc_q[15:0])) && (acc_q[31:16] == $past(acc_q[31:16])))
      else $error("Low word not inverted");
   AST_TWOS: assert property ((cur_go && op == aos_pkg::OP_TWOS_COMPLEMENT) |=>  // RL3
      16'(acc_q[15:0] + $past(acc_q[15:0])) == 16'h0000)
      else $error("Low word not negated");
   AST_DEC: assert property ((cur_go && op == aos_pkg::OP_BYTE_DECREMENT) |=>  // RL4
      acc_q[7:0] == 8'($past(acc_q[7:0]) - $past(amount)))
      else $error("Byte decrement wrong");
   AST_INC: assert property ((cur_go && op == aos_pkg::OP_BYTE_INCREMENT) |=>  // RL5
      acc_q[7:0] == 8'($past(acc_q[7:0]) + $past(amount)))
      else $error("Byte increment wrong");
   AST_BYTE_UPPER: assert property ((cur_go && (op == aos_pkg::OP_BYTE_INCREMENT ||  // RL18
      op == aos_pkg::OP_BYTE_DECREMENT)) |=> $stable(acc_q[31:8]) && !O_EXEC_VALID)
      else $error("Upper accumulator bits changed");
   AST_DATA_FETCH: assert property ((cur_go && op == aos_pkg::OP_DATA_WORD_EXEC) |=>  // RL8
      O_MEM_REQ && O_MEM_SPACE == aos_pkg::SPACE_DATA_WORD && O_MEM_ADDR == $past(arg))
      else $error("Data word fetch missing");
   AST_FLAG_FETCH: assert property ((cur_go && op == aos_pkg::OP_FLAG_WORD_EXEC) |=>  // RL9
      O_MEM_REQ && O_MEM_SPACE == aos_pkg::SPACE_FLAG_WORD && O_MEM_ADDR == $past(arg))
      else $error("Flag word fetch missing");
   AST_INDIRECT: assert property ((cur_go && op == aos_pkg::OP_INDIRECT_FORMAL) |=>  // RL11
      O_MEM_REQ && O_MEM_SPACE == aos_pkg::SPACE_FORMAL && O_MEM_ADDR == $past(acc_q[7:0]))
      else $error("Indirect formal number wrong");
   AST_SYS_WINDOW: assert property ((state_q == aos_pkg::S_FETCH_CODE &&  // RL12
      space_q == aos_pkg::SPACE_SYSTEM_DATA) |-> addr_q >= aos_pkg::SYSTEM_DATA_FIRST &&
      addr_q <= aos_pkg::SYSTEM_DATA_LAST)
      else $error("System data address outside window");
   AST_PAIR: assert property ((state_q == aos_pkg::S_FETCH_PARAM && I_MEM_ACK &&  // RL16
      !subst_formal_q) ##1 (cur_go && op[7:4] != 4'h1 && op[7:4] != 4'h2) |=> O_EXEC_VALID &&
      O_EXEC_SUBST && O_EXEC_OPERAND == $past(subst_val_q))
      else $error("Substituted operand not applied");

   COV_SUBST: cover property (O_EXEC_VALID && O_EXEC_SUBST);
   COV_TWO_WORD: cover property (state_q == aos_pkg::S_FETCH_SECOND && I_MEM_ACK);
   COV_CONVERT: cover property (conv_done);
   COV_REJECT: cover property (O_SUBST_REJECT);

endmodule // aos_executor

// >>> aos_mem_model.sv
// Parameter memory model serving the executor's read port.
// Assumes one clock shared with the executor; answer delay is set by the bench.
module aos_mem_model
(
   // Clock and reset
   input  wire logic        i_clock,
   input  wire logic        i_srst,
   // Read port
   input  wire logic        i_req,
   input  wire logic [1:0]  i_space,
   input  wire logic [7:0]  i_addr,
   input  wire logic [2:0]  i_delay,
   output logic             o_ack,
   output logic [15:0]      o_data,
   output logic             o_block_type
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] mem [4][256];
   logic        blk [256];
   logic [2:0]  cnt_q;
   always_ff @(posedge i_clock)
   begin
      if (i_srst)
      begin
         o_ack        <= 1'b0;
         cnt_q        <= 3'h0;
         o_data       <= 16'h5a5a;
         o_block_type <= 1'b0;
      end
      else if (o_ack)
      begin
         // Released bus shows garbage
         o_ack        <= 1'b0;
         o_data       <= ~o_data;
         o_block_type <= ~o_block_type;
         cnt_q        <= 3'h0;
      end
      else if (i_req && cnt_q >= i_delay)
      begin
         o_ack        <= 1'b1;
         o_data       <= mem[i_space][i_addr];
         o_block_type <= blk[i_addr];
      end
      else if (i_req)
         cnt_q <= cnt_q + 3'h1;
   end
endmodule // aos_mem_model

// >>> tb.sv
// Self-checking bench for the accumulator and substitution executor.
// Assumes the memory model file is compiled first.
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
   $display("ERROR %0t: got %h expected %h", $time, g, e); end end
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   int          mismatches, comparisons, cycles, i;
   logic [31:0] lfsr_q = 32'h472d;
   logic        clk, srst, iv, rdy, lv, mreq, mack, mbt, ev, es, er, gv, gr;
   logic [15:0] iw, ie, mdat, ew, eo, v, tw, w1, w2;
   logic [31:0] ld, acc, a, e;
   logic [1:0]  msp;
   logic [7:0]  madr, k, ad, op;
   logic [2:0]  dly;
   aos_executor u_aos_executor (.I_CLOCK(clk), .I_SRST(srst), .I_INSTR_VALID(iv),
      .I_INSTR_WORD(iw), .I_INSTR_EXT(ie), .O_INSTR_READY(rdy), .I_ACC_LOAD_VALID(lv),
      .I_ACC_LOAD_DATA(ld), .O_ACCUMULATOR(acc), .O_MEM_REQ(mreq), .O_MEM_SPACE(msp),
      .O_MEM_ADDR(madr), .I_MEM_ACK(mack), .I_MEM_DATA(mdat), .I_MEM_BLOCK_TYPE(mbt),
      .O_EXEC_VALID(ev), .O_EXEC_WORD(ew), .O_EXEC_OPERAND(eo), .O_EXEC_SUBST(es),
      .O_SUBST_REJECT(er));
   aos_mem_model u_aos_mem_model (.i_clock(clk), .i_srst(srst), .i_req(mreq),
      .i_space(msp), .i_addr(madr), .i_delay(dly), .o_ack(mack), .o_data(mdat),
      .o_block_type(mbt));
   function automatic logic [31:0] rnd();
      lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
      return lfsr_q;
   endfunction
   // Floor conversion, zero strictly between minus one and zero
   function automatic logic [31:0] f2x(input logic [31:0] x);
      int                 sh;
      logic signed [63:0] m;
      logic signed [63:0] r;
      sh = int'($signed(x[31:24])) - 23;
      m  = 64'($signed(x[23:0]));
      if (sh >= 0)
         r = m <<< sh;
      else
      begin
         r = m >>> (-sh);
         if (r == -64'sd1 && (m & ((64'sd1 <<< (-sh)) - 64'sd1)) != 64'sd0)
            r = 64'sd0;
      end
      return r[31:0];
   endfunction
   task automatic finish_test();
      $display("Counts: %0d mismatches, %0d comparisons", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic issue(input logic [15:0] w);
      @(negedge clk);
      while (rdy !== 1'b1)
         @(negedge clk);
      iv = 1'b1;
      iw = w;
      ie = 16'(rnd());
      @(negedge clk);
      iv = 1'b0;
   endtask
   task automatic load(input logic [31:0] x);
      @(negedge clk);
      lv = 1'b1;
      ld = x;
      @(negedge clk);
      lv = 1'b0;
   endtask
   task automatic wait_out();
      gv = 1'b0;
      gr = 1'b0;
      for (int n = 0; n < 60 && !gv && !gr; n++)
      begin
         gv = (ev === 1'b1);
         gr = (er === 1'b1);
         if (!gv && !gr)
            @(negedge clk);
      end
   endtask
   task automatic expect_exec(input logic [15:0] w, input logic [15:0] o);
      wait_out();
      `CHK(gv, 1'b1)
      `CHK(ew, w)
      `CHK(eo, o)
   endtask
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         finish_test();
      end
   end
   initial
   begin
      {iv, lv, iw, ie, ld, dly} = '0;
      srst = 1'b1;
      repeat (5) @(negedge clk);
      srst = 1'b0;
      `CHK({rdy, acc, ev, mreq, er}, {1'b1, 32'h0, 3'h0})
      for (i = 0; i < 40; i++)
      begin
         a = rnd();
         k = (i < 2) ? 8'hff >> (7 * i) : 8'(rnd() % 255 + 1);
         load(a);
         issue({i[0] ? aos_pkg::OP_BYTE_INCREMENT : aos_pkg::OP_BYTE_DECREMENT, k});
         e = {a[31:8], i[0] ? a[7:0] + k : a[7:0] - k};
         `CHK(acc, e)
         issue({aos_pkg::OP_ONES_COMPLEMENT, 8'h00});
         `CHK(acc[15:0], ~e[15:0])
         issue({aos_pkg::OP_TWOS_COMPLEMENT, 8'h00});
         `CHK(acc[15:0], e[15:0] + 16'h1)
      end
      for (i = 0; i < 20; i++)
      begin
         a = rnd();
         a[31:24] = a[31:24] % 8'd31 - 8'd6;
         if (i < 2)
            a = i ? 32'h0080_0000 : 32'h00c0_0000;
         load(a);
         issue({aos_pkg::OP_FLOAT_TO_FIXED, 8'h00});
         repeat (2) @(negedge clk);
         `CHK(acc, f2x(a))
      end
      for (i = 0; i < 16; i++)
      begin
         dly = 3'(rnd());
         a = rnd();
         ad = (i[0] && a[7:0] == 8'hff) ? 8'hfe : a[7:0];
         v = a[31:16];
         tw = {8'h40, a[15:8]};
         u_aos_mem_model.mem[{1'b0, i[0]}][ad] = v;
         issue({i[0] ? aos_pkg::OP_FLAG_WORD_EXEC : aos_pkg::OP_DATA_WORD_EXEC, ad});
         issue(tw);
         expect_exec(tw, v);
         `CHK(es, 1'b1)
         tw[15] = i[2];
         issue(tw);
         expect_exec(tw, i[2] ? ie : {8'h00, tw[7:0]});
         `CHK(es, 1'b0)
         load(a);
         issue({i[0] ? aos_pkg::OP_FLAG_WORD_EXEC : aos_pkg::OP_DATA_WORD_EXEC, ad});
         issue({aos_pkg::OP_BYTE_INCREMENT, 8'h01});
         `CHK(acc, {a[31:8], 8'(a[7:0] + v[7:0])})
         u_aos_mem_model.mem[2][ad] = v;
         u_aos_mem_model.blk[ad] = i[1];
         issue({aos_pkg::OP_FORMAL_EXEC, ad});
         if (!i[1])
         begin
            wait_out();
            `CHK(gr, 1'b1)
         end
         op = aos_pkg::OP_OPEN_DATA_BLOCK + 8'(i % 5);
         issue({op, a[15:8]});
         expect_exec({op, a[15:8]}, i[1] ? v : {8'h00, a[15:8]});
         `CHK(es, i[1])
         tw = {aos_pkg::OP_CALL_PROGRAM, a[23:16]};
         u_aos_mem_model.mem[2][ad] = tw;
         load({24'h0, ad});
         issue({aos_pkg::OP_INDIRECT_FORMAL, 8'h00});
         expect_exec(tw, {8'h00, tw[7:0]});
         ad = aos_pkg::SYSTEM_DATA_FIRST + 8'(i % 4);
         w1 = {1'b1, a[14:0]};
         w2 = 16'(rnd());
         u_aos_mem_model.mem[3][ad] = w1;
         u_aos_mem_model.mem[3][ad + 8'h1] = w2;
         issue({aos_pkg::OP_SYSTEM_DATA, ad});
         expect_exec(w1, w2);
      end
      for (i = 0; i < 2; i++)
      begin
         issue({aos_pkg::OP_SYSTEM_DATA, i ? 8'h40 : 8'h3b});
         wait_out();
         `CHK(gr, 1'b1)
      end
      finish_test();
   end
endmodule // tb
